// ===== design/rpcs_defines.svh
// Constants and functional notes for the receive per-channel signaling buffers
// Functional notes
// - E1 AB-only: serial output sends ABAB
// - T1 AB-only: delay signaling 24 multiframes
// - T1 AB-only: input to output every 24 multiframes
// - SF: AB(N-1) then AB(N); freeze keeps older
// - Outputs use output half, system-bus slot index
// - Debounce shifts pairs, glitch pairs take input
// - Idle unassigned slot: replace embedded F-bits (code replaces them only when the AB-only control bit is also set)
// - AB-only clear: plain throughput; set: replacement
// - Idle: write high half, output low half
// - Report enabled changes; buffer always updated (code reports none in debounce mode or in T1 AB-only mode)
// - Local select picks buffered or local bits
// - Local plus insert: local bits into PCM
// - No update in freeze or non-signaling mode
// - No debounce: transfer at D-bit or TS16
// - Debounce: output updates per sampled bit
// - Buffer: output ABCD 7:4, input 3:0
// - Rx slip: first bit in bit 7
// - Tx slip high: first bit in bit 7
`ifndef RPCS_DEFINES_SVH
`define RPCS_DEFINES_SVH
`define RPCS_ADDR_W 9
`define RPCS_BASE_TX_HI 9'h160
`define RPCS_BASE_CTRL 9'h180
`define RPCS_BASE_SIG 9'h1a0
`define RPCS_BASE_RX_LO 9'h1c0
`define RPCS_BASE_RX_HI 9'h1e0
`define RPCS_SLOTS 32
`define RPCS_FRAMES_PER_XFER 5'h18
`define RPCS_E1_SIG_SLOT 5'h10
`define RPCS_FIFO_DEPTH 16
`define RPCS_CTRL_AB 7
`define RPCS_CTRL_IDLE 6
`define RPCS_CTRL_REPORT 5
`define RPCS_CTRL_LOCAL 4
`endif

// ===== design/rpcs_pkg.sv
// Types shared by the receive per-channel signaling block
package rpcs_pkg;
  typedef struct packed {
    logic [4:0] slot;
    logic [3:0] abcd;
  } rpcs_change_s;
  typedef struct packed {
    logic we;
    logic re;
    logic [8:0] addr;
    logic [7:0] wdata;
  } rpcs_cpu_s;
  typedef enum logic [1:0] {rpcs_rx_idle, rpcs_rx_run} rpcs_rx_state_e;
endpackage

// ===== design/rpcs_fifo.sv
// Parameterised valid/ready FIFO in flip-flops
`timescale 1ns/10ps
module rpcs_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rptr];
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wptr] <= in_data_i;
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + AW'(1);
      end
      if (pop)
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // rpcs_fifo

// ===== design/rpcs_top.sv
// Receive per-channel control, signaling buffers and slip buffer halves
`timescale 1ns/10ps
`include "rpcs_defines.svh"
module rpcs_top #(
  parameter int SLOTS = `RPCS_SLOTS,
  parameter int FIFO_DEPTH = `RPCS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Processor port
  input wire logic cpu_we_i,
  input wire logic cpu_re_i,
  input wire logic [8:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  // Framer mode
  input wire logic e1_mode_i,
  input wire logic sf_format_i,
  input wire logic sig_mode_i,
  input wire logic sig_freeze_i,
  input wire logic debounce_i,
  // Receive framer side
  input wire logic rx_byte_valid_i,
  input wire logic [4:0] rx_slot_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_assigned_i,
  input wire logic rx_frame_start_i,
  input wire logic rx_sig_valid_i,
  input wire logic [4:0] rx_sig_slot_i,
  input wire logic [1:0] rx_sig_bit_i,
  input wire logic rx_sig_value_i,
  input wire logic rx_dbit_update_i,
  input wire logic rx_mf_start_i,
  // Transmit PCM serial input
  input wire logic tx_pcm_valid_i,
  input wire logic [4:0] tx_pcm_slot_i,
  input wire logic [7:0] tx_pcm_byte_i,
  // System bus side
  input wire logic sb_req_i,
  input wire logic [4:0] sb_slot_i,
  input wire logic sb_sig_frame_i,
  input wire logic sb_insert_i,
  input wire logic sb_fbit_pos_i,
  input wire logic [2:0] sb_fbit_idx_i,
  output logic [7:0] rx_pcm_serial_out_o,
  output logic [3:0] rx_sig_serial_out_o,
  // Signaling change stack
  output logic chg_valid_o,
  input wire logic chg_ready_i,
  output rpcs_pkg::rpcs_change_s chg_data_o
);
  logic [7:0] tx_slip_high [SLOTS];
  logic [7:0] rx_channel_ctrl [SLOTS];
  logic [7:0] rx_sig_buffer [SLOTS];
  logic [7:0] rx_slip_low [SLOTS];
  logic [7:0] rx_slip_high [SLOTS];
  logic [3:0] ab_prev [SLOTS];
  logic [4:0] frame_cnt;
  logic [7:0] pcm_q;
  logic [3:0] sig_q;

  function automatic logic in_win(input logic [8:0] a, input logic [8:0] base);
    in_win = (a[8:5] == base[8:5]);
  endfunction
  // Debounce pair update: returns {N, N-1}
  function automatic logic [1:0] deb(input logic n, input logic nm1, input logic x);
    deb = ((n != x) && (nm1 == x)) ? {x, x} : {x, n};
  endfunction

  wire [4:0] ws = cpu_addr_i[4:0];
  wire hit_txh = in_win(cpu_addr_i, `RPCS_BASE_TX_HI);
  wire hit_ctl = in_win(cpu_addr_i, `RPCS_BASE_CTRL);
  wire hit_sig = in_win(cpu_addr_i, `RPCS_BASE_SIG);
  wire hit_rlo = in_win(cpu_addr_i, `RPCS_BASE_RX_LO);
  wire hit_rhi = in_win(cpu_addr_i, `RPCS_BASE_RX_HI);
  wire [7:0] rd_mux = hit_txh ? tx_slip_high[ws] : hit_ctl ? rx_channel_ctrl[ws] :
    hit_sig ? rx_sig_buffer[ws] : hit_rlo ? rx_slip_low[ws] : hit_rhi ? rx_slip_high[ws] : 8'h00;

  // Signaling update decode
  wire [4:0] ss = rx_sig_slot_i;
  wire [7:0] sctl = rx_channel_ctrl[ss];
  wire s_ab = sctl[`RPCS_CTRL_AB];
  wire sig_upd_ok = sig_mode_i && !sig_freeze_i;
  wire [3:0] old_in = rx_sig_buffer[ss][3:0];
  wire [3:0] old_out = rx_sig_buffer[ss][7:4];
  wire [1:0] bi = 2'h3 - rx_sig_bit_i;
  wire t1_ab = !e1_mode_i && s_ab;
  wire [3:0] plain_in = old_in & ~(4'h1 << bi) | ({3'h0, rx_sig_value_i} << bi);
  // SF AB-only: input half CD holds AB(N), AB holds AB(N-1)
  wire [3:0] sf_in = (rx_sig_bit_i == 2'h0) ? {old_in[1], old_in[0], rx_sig_value_i, old_in[0]}
    : {old_in[3], old_in[2], old_in[1], rx_sig_value_i};
  wire [1:0] db_pair = deb(old_out[bi], ab_prev[ss][bi], rx_sig_value_i);
  wire [3:0] next_in = (t1_ab && sf_format_i) ? sf_in : plain_in;
  wire [3:0] next_out_db = old_out & ~(4'h1 << bi) | ({3'h0, db_pair[1]} << bi);
  wire [3:0] next_prev_db = ab_prev[ss] & ~(4'h1 << bi) | ({3'h0, db_pair[0]} << bi);
  wire e1_xfer = e1_mode_i && (rx_sig_bit_i == 2'h0);
  wire t1_xfer = !e1_mode_i && !s_ab && rx_dbit_update_i;
  wire do_sig = rx_sig_valid_i && sig_upd_ok;
  wire xfer_now = do_sig && !debounce_i && (e1_xfer || t1_xfer);
  wire [3:0] xfer_val = e1_xfer ? {old_in[3:1], rx_sig_value_i} : next_in;
  wire ab_tick = sig_upd_ok && rx_mf_start_i && (frame_cnt == `RPCS_FRAMES_PER_XFER - 5'h1);
  wire chg_ev = xfer_now && (xfer_val != old_out) && sctl[`RPCS_CTRL_REPORT];
  logic fifo_ready;

  // System-bus output selection
  wire [7:0] octl = rx_channel_ctrl[sb_slot_i];
  wire [3:0] buf_sig = rx_sig_buffer[sb_slot_i][7:4];
  wire [3:0] local_sig = octl[3:0];
  wire [3:0] e1_sig = (e1_mode_i && octl[`RPCS_CTRL_AB]) ? {buf_sig[3:2], buf_sig[3:2]} : buf_sig;
  wire [3:0] sel_sig = octl[`RPCS_CTRL_LOCAL] ? local_sig : e1_sig;
  wire [7:0] data_src = octl[`RPCS_CTRL_IDLE] ? rx_slip_low[sb_slot_i] : rx_slip_high[sb_slot_i];
  wire ins_sig = sb_insert_i && sb_sig_frame_i;
  wire [7:0] sig_ins = {data_src[7:4], sel_sig};
  wire fbit_rep = !rx_assigned_i && octl[`RPCS_CTRL_IDLE] && octl[`RPCS_CTRL_AB] && sb_fbit_pos_i;
  wire [7:0] fmask = 8'h80 >> sb_fbit_idx_i;
  wire [7:0] pcm_base = ins_sig ? sig_ins : data_src;
  wire [7:0] next_pcm = fbit_rep ? ((pcm_base & ~fmask) | (octl[`RPCS_CTRL_AB] ? fmask : 8'h00)) : pcm_base;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      frame_cnt <= '0;
    else if (rx_mf_start_i)
      frame_cnt <= (frame_cnt == `RPCS_FRAMES_PER_XFER - 5'h1) ? 5'h0 : frame_cnt + 5'h1;
    else if (rx_frame_start_i && frame_cnt == `RPCS_FRAMES_PER_XFER)
      frame_cnt <= '0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < SLOTS; i++)
      begin
        rx_channel_ctrl[i] <= 8'h00;
        rx_sig_buffer[i] <= 8'h00;
        ab_prev[i] <= 4'h0;
      end
    end
    else
    begin
      if (do_sig)
      begin
        rx_sig_buffer[ss][3:0] <= next_in;
        if (debounce_i)
        begin
          rx_sig_buffer[ss][7:4] <= next_out_db;
          ab_prev[ss] <= next_prev_db;
        end
        else if (xfer_now)
          rx_sig_buffer[ss][7:4] <= xfer_val;
      end
      if (ab_tick)
        for (int i = 0; i < SLOTS; i++)
          if (!e1_mode_i && rx_channel_ctrl[i][`RPCS_CTRL_AB] && !debounce_i)
            rx_sig_buffer[i][7:4] <= rx_sig_buffer[i][3:0];
      if (cpu_we_i && hit_sig)
        rx_sig_buffer[ws] <= cpu_wdata_i;
      if (cpu_we_i && hit_ctl)
        rx_channel_ctrl[ws] <= cpu_wdata_i;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (rx_byte_valid_i && rx_assigned_i)
    begin
      rx_slip_high[rx_slot_i] <= rx_byte_i;
      if (!rx_channel_ctrl[rx_slot_i][`RPCS_CTRL_IDLE])
        rx_slip_low[rx_slot_i] <= rx_byte_i;
    end
    if (tx_pcm_valid_i)
      tx_slip_high[tx_pcm_slot_i] <= tx_pcm_byte_i;
    if (cpu_we_i && hit_rlo)
      rx_slip_low[ws] <= cpu_wdata_i;
    if (cpu_we_i && hit_rhi)
      rx_slip_high[ws] <= cpu_wdata_i;
    if (cpu_we_i && hit_txh)
      tx_slip_high[ws] <= cpu_wdata_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      pcm_q <= 8'h00;
      sig_q <= 4'h0;
      cpu_rdata_o <= 8'h00;
    end
    else
    begin
      if (sb_req_i)
      begin
        pcm_q <= next_pcm;
        sig_q <= sel_sig;
      end
      if (cpu_re_i)
        cpu_rdata_o <= rd_mux;
    end
  end
  assign rx_pcm_serial_out_o = pcm_q;
  assign rx_sig_serial_out_o = sig_q;

  rpcs_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_chg_fifo (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .in_valid_i(chg_ev),
    .in_ready_o(fifo_ready),
    .in_data_i({ss, xfer_val}),
    .out_valid_o(chg_valid_o),
    .out_ready_i(chg_ready_i),
    .out_data_o(chg_data_o)
  );

  a_local_sig_out: assert property (@(posedge mclk_i) disable iff (srst_i)
    sb_req_i && octl[`RPCS_CTRL_LOCAL] |=> rx_sig_serial_out_o == $past(local_sig))
    else $error("local signaling not driven");
  a_idle_low_src: assert property (@(posedge mclk_i) disable iff (srst_i)
    sb_req_i && octl[`RPCS_CTRL_IDLE] && !ins_sig && !fbit_rep |=> rx_pcm_serial_out_o == $past(rx_slip_low[sb_slot_i]))
    else $error("idle slot not from low half");
  a_freeze_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    rx_sig_valid_i && sig_freeze_i && !(cpu_we_i && hit_sig) && !ab_tick |=> $stable(rx_sig_buffer[$past(ss)]))
    else $error("signaling updated in freeze");
  a_chg_capture: assert property (@(posedge mclk_i) disable iff (srst_i)
    chg_ev && !chg_valid_o |=> chg_valid_o)
    else $error("change not reported");
  a_e1_abab: assert property (@(posedge mclk_i) disable iff (srst_i)
    sb_req_i && e1_mode_i && octl[`RPCS_CTRL_AB] && !octl[`RPCS_CTRL_LOCAL]
    |=> rx_sig_serial_out_o[3:2] == rx_sig_serial_out_o[1:0])
    else $error("E1 AB-only output not ABAB");
  a_ctrl_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    cpu_we_i && hit_ctl |=> rx_channel_ctrl[$past(ws)] == $past(cpu_wdata_i))
    else $error("control write lost");
  a_rx_hi_fill: assert property (@(posedge mclk_i) disable iff (srst_i)
    rx_byte_valid_i && rx_assigned_i && !cpu_we_i |=> rx_slip_high[$past(rx_slot_i)] == $past(rx_byte_i))
    else $error("rx high half not filled");
  a_tx_hi_fill: assert property (@(posedge mclk_i) disable iff (srst_i)
    tx_pcm_valid_i && !cpu_we_i |=> tx_slip_high[$past(tx_pcm_slot_i)] == $past(tx_pcm_byte_i))
    else $error("tx high half not filled");

  // Signaling update and system-bus fetch steps
  sequence s_sig_take;
    do_sig && !(cpu_we_i && hit_sig);
  endsequence

  sequence s_fetch_plain;
    sb_req_i && !ins_sig && !fbit_rep;
  endsequence

  sequence s_fetch_buffered;
    sb_req_i && !octl[`RPCS_CTRL_LOCAL];
  endsequence

  a_input_half: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_sig_take
    |=> rx_sig_buffer[$past(ss)][3:0] == $past(next_in))
    else $error("input half not updated");

  a_dbit_xfer: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_sig_take ##0 (!debounce_i && t1_xfer)
    |=> rx_sig_buffer[$past(ss)][7:4] == $past(xfer_val))
    else $error("D-bit transfer missing");

  a_ts16_xfer: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_sig_take ##0 (!debounce_i && e1_xfer)
    |=> rx_sig_buffer[$past(ss)][7:4] == $past(xfer_val))
    else $error("E1 transfer missing");

  a_debounce_out: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_sig_take ##0 debounce_i
    |=> rx_sig_buffer[$past(ss)][7:4] == $past(next_out_db))
    else $error("debounced output not updated");

  a_debounce_pair: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_sig_take ##0 debounce_i
    |=> ab_prev[$past(ss)] == $past(next_prev_db))
    else $error("debounce history not updated");

  a_sf_pair: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_sig_take ##0 (t1_ab && sf_format_i && rx_sig_bit_i == 2'h0)
    |=> rx_sig_buffer[$past(ss)][3:2] == $past(old_in[1:0]))
    else $error("older AB pair not kept");

  a_ab_move: assert property (@(posedge mclk_i) disable iff (srst_i)
    ab_tick && t1_ab && !debounce_i && !(cpu_we_i && hit_sig)
    |=> rx_sig_buffer[$past(ss)][7:4] == $past(old_in))
    else $error("AB-only transfer missing");

  a_frame_range: assert property (@(posedge mclk_i) disable iff (srst_i)
    frame_cnt < `RPCS_FRAMES_PER_XFER)
    else $error("frame counter out of range");

  a_no_sig_mode: assert property (@(posedge mclk_i) disable iff (srst_i)
    rx_sig_valid_i && !sig_mode_i && !(cpu_we_i && hit_sig)
    |=> rx_sig_buffer[$past(ss)] == $past(rx_sig_buffer[ss]))
    else $error("signaling updated in non-signaling mode");

  a_chg_push: assert property (@(posedge mclk_i) disable iff (srst_i)
    chg_ev && fifo_ready
    |=> chg_valid_o)
    else $error("change not stacked");

  a_chg_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
    chg_valid_o && !chg_ready_i
    |=> chg_valid_o && $stable(chg_data_o))
    else $error("change entry lost before pop");

  a_buf_sig_out: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_fetch_buffered ##0 !(e1_mode_i && octl[`RPCS_CTRL_AB])
    |=> rx_sig_serial_out_o == $past(buf_sig))
    else $error("buffered signaling not driven");

  a_ab_clear_pass: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_fetch_buffered ##0 !octl[`RPCS_CTRL_AB]
    |=> rx_sig_serial_out_o == $past(buf_sig))
    else $error("ABCD throughput altered");

  a_pcm_normal: assert property (@(posedge mclk_i) disable iff (srst_i)
    s_fetch_plain ##0 !octl[`RPCS_CTRL_IDLE]
    |=> rx_pcm_serial_out_o == $past(rx_slip_high[sb_slot_i]))
    else $error("normal slot not from high half");

  a_sig_insert: assert property (@(posedge mclk_i) disable iff (srst_i)
    sb_req_i && ins_sig && !fbit_rep
    |=> rx_pcm_serial_out_o[3:0] == $past(sel_sig))
    else $error("signaling not inserted");

  a_fbit_force: assert property (@(posedge mclk_i) disable iff (srst_i)
    sb_req_i && fbit_rep
    |=> (rx_pcm_serial_out_o & $past(fmask)) == $past(fmask))
    else $error("embedded F-bit not replaced");

  a_idle_low_keep: assert property (@(posedge mclk_i) disable iff (srst_i)
    rx_byte_valid_i && rx_assigned_i && rx_channel_ctrl[rx_slot_i][`RPCS_CTRL_IDLE] && !cpu_we_i
    |=> rx_slip_low[$past(rx_slot_i)] == $past(rx_slip_low[rx_slot_i]))
    else $error("idle code overwritten");

  a_read_data: assert property (@(posedge mclk_i) disable iff (srst_i)
    cpu_re_i
    |=> cpu_rdata_o == $past(rd_mux))
    else $error("read data wrong");

  a_read_harmless: assert property (@(posedge mclk_i) disable iff (srst_i)
    cpu_re_i && !cpu_we_i
    |=> rx_channel_ctrl[$past(ws)] == $past(rx_channel_ctrl[ws]))
    else $error("read changed control");

  a_sig_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    cpu_we_i && hit_sig
    |=> rx_sig_buffer[$past(ws)] == $past(cpu_wdata_i))
    else $error("signaling write lost");

  a_low_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    cpu_we_i && hit_rlo
    |=> rx_slip_low[$past(ws)] == $past(cpu_wdata_i))
    else $error("low half write lost");

  a_high_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    cpu_we_i && hit_rhi
    |=> rx_slip_high[$past(ws)] == $past(cpu_wdata_i))
    else $error("high half write lost");

  a_tx_write: assert property (@(posedge mclk_i) disable iff (srst_i)
    cpu_we_i && hit_txh
    |=> tx_slip_high[$past(ws)] == $past(cpu_wdata_i))
    else $error("tx high half write lost");
endmodule // rpcs_top

// ===== tb/rpcs_sb_model.sv
// System-bus backplane model: slot fetches and change stack drain
`timescale 1ns/10ps
module rpcs_sb_model (
  // Clock
  input wire logic mclk_i,
  // Bench commands
  input wire logic fetch_i,
  input wire logic [4:0] slot_i,
  input wire logic stall_i,
  // Block system-bus side
  output logic sb_req_o,
  output logic [4:0] sb_slot_o,
  input wire logic [7:0] pcm_i,
  input wire logic [3:0] sig_i,
  input wire logic chg_valid_i,
  output logic chg_ready_o,
  input wire rpcs_pkg::rpcs_change_s chg_i,
  // Captured results
  output logic [7:0] pcm_o,
  output logic [3:0] sig_o,
  output rpcs_pkg::rpcs_change_s chg_o,
  output logic [7:0] chg_cnt_o
);
  logic req_d = 1'h0;
  initial
  begin
    sb_req_o = 1'h0;
    sb_slot_o = 5'h00;
    chg_ready_o = 1'h0;
    chg_cnt_o = 8'h00;
  end
  // Slot number toggles while no fetch is made
  always @(posedge mclk_i)
  begin
    sb_req_o <= fetch_i;
    sb_slot_o <= fetch_i ? slot_i : ~sb_slot_o;
    req_d <= sb_req_o;
    if (req_d)
    begin
      pcm_o <= pcm_i;
      sig_o <= sig_i;
    end
    chg_ready_o <= stall_i ? ~chg_ready_o : 1'h1;
    if (chg_valid_i && chg_ready_o)
    begin
      chg_o <= chg_i;
      chg_cnt_o <= chg_cnt_o + 8'h01;
    end
  end
endmodule // rpcs_sb_model

// ===== tb/tb_rpcs_top.sv
// Self-checking bench for the receive per-channel signaling block
`timescale 1ns/10ps
module tb_rpcs_top;
  logic mclk_i, srst_i = 1'h1, we = 1'h0, re = 1'h0, fz = 1'h0, svl = 1'h0, dbu = 1'h0;
  logic rbv = 1'h0, tpv = 1'h0, fetch = 1'h0, stall = 1'h0, sval = 1'h0, lo = 1'h0;
  logic asg = 1'h1, e1 = 1'h0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wd = 8'h00, rbyte = 8'h00, rdata, pcm, pcm_q, cnt;
  logic [4:0] rslot = 5'h00, fslot = 5'h00, sbslot;
  logic [1:0] sbit = 2'h0;
  logic [3:0] sig, sig_q;
  logic sbreq, cv, cr;
  rpcs_pkg::rpcs_change_s cd, cq;
  logic [24:0] rows [6] = '{{9'h161, 8'h3c, 8'h3c}, {9'h19f, 8'h81, 8'h81}, {9'h1a7, 8'ha5, 8'ha5},
    {9'h1c0, 8'h01, 8'h01}, {9'h1ff, 8'hff, 8'hff}, {9'h07f, 8'h77, 8'h00}};
  int error_cnt = 0, total_checks = 0;
  rpcs_top rpcs_top_inst (.mclk_i(mclk_i), .srst_i(srst_i), .cpu_we_i(we), .cpu_re_i(re),
    .cpu_addr_i(addr), .cpu_wdata_i(wd), .cpu_rdata_o(rdata), .e1_mode_i(e1), .sf_format_i(lo),
    .sig_mode_i(1'h1), .sig_freeze_i(fz), .debounce_i(lo), .rx_byte_valid_i(rbv),
    .rx_slot_i(rslot), .rx_byte_i(rbyte), .rx_assigned_i(asg), .rx_frame_start_i(lo),
    .rx_sig_valid_i(svl), .rx_sig_slot_i(5'h06), .rx_sig_bit_i(sbit), .rx_sig_value_i(sval),
    .rx_dbit_update_i(dbu), .rx_mf_start_i(lo), .tx_pcm_valid_i(tpv), .tx_pcm_slot_i(rslot),
    .tx_pcm_byte_i(rbyte), .sb_req_i(sbreq), .sb_slot_i(sbslot), .sb_sig_frame_i(lo),
    .sb_insert_i(lo), .sb_fbit_pos_i(lo), .sb_fbit_idx_i(3'h0), .rx_pcm_serial_out_o(pcm),
    .rx_sig_serial_out_o(sig), .chg_valid_o(cv), .chg_ready_i(cr), .chg_data_o(cd));
  rpcs_sb_model rpcs_sb_model_inst (.mclk_i(mclk_i), .fetch_i(fetch), .slot_i(fslot),
    .stall_i(stall), .sb_req_o(sbreq), .sb_slot_o(sbslot), .pcm_i(pcm), .sig_i(sig),
    .chg_valid_i(cv), .chg_ready_o(cr), .chg_i(cd), .pcm_o(pcm_q), .sig_o(sig_q),
    .chg_o(cq), .chg_cnt_o(cnt));
  initial
  begin
    mclk_i = 1'h0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  task automatic chk(input string nm, input logic [8:0] s, input logic [8:0] e);
    total_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    we <= 1'h1;
    addr <= a;
    wd <= d;
    @(posedge mclk_i);
    we <= 1'h0;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    re <= 1'h1;
    addr <= a;
    @(posedge mclk_i);
    re <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic fetch_slot(input logic [4:0] s);
    @(posedge mclk_i);
    fetch <= 1'h1;
    fslot <= s;
    @(posedge mclk_i);
    fetch <= 1'h0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  // Bits A to D of slot 6, transfer qualified with the D bit
  task automatic abcd(input logic [3:0] n);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk_i);
      svl <= 1'h1;
      sbit <= 2'(i);
      sval <= n[3-i];
      dbu <= (i == 3);
    end
    @(posedge mclk_i);
    svl <= 1'h0;
    dbu <= 1'h0;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    error_cnt++;
    tally_and_finish;
  end
  initial
  begin
    logic [7:0] d;
    logic [7:0] c0;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'h0;
    foreach (rows[i]) wr(rows[i][24:16], rows[i][15:8]);
    foreach (rows[i])
    begin
      rd(rows[i][24:16], d);
      chk("array readback", d, rows[i][7:0]);
    end
    $display("test register arrays done");
    wr(9'h183, 8'h40);
    wr(9'h1c3, 8'h5a);
    @(posedge mclk_i);
    rbv <= 1'h1;
    rslot <= 5'h03;
    rbyte <= 8'hc3;
    @(posedge mclk_i);
    rbv <= 1'h0;
    rd(9'h1e3, d);
    chk("rx slip high", d, 8'hc3);
    fetch_slot(5'h03);
    chk("idle pcm", pcm_q, 8'h5a);
    @(posedge mclk_i);
    tpv <= 1'h1;
    rslot <= 5'h02;
    rbyte <= 8'h96;
    @(posedge mclk_i);
    tpv <= 1'h0;
    rd(9'h162, d);
    chk("tx slip high", d, 8'h96);
    $display("test slip buffers done");
    wr(9'h184, 8'h1a);
    fetch_slot(5'h04);
    chk("local sig", sig_q, 4'ha);
    wr(9'h186, 8'h20);
    stall <= 1'h1;
    c0 = cnt;
    abcd(4'h9);
    rd(9'h1a6, d);
    chk("sig buffer", d, 8'h99);
    for (int i = 0; i < 40 && cnt === c0; i++) @(posedge mclk_i);
    #1 chk("change entry", cq, {5'h06, 4'h9});
    fetch_slot(5'h06);
    chk("buffered sig", sig_q, 4'h9);
    @(posedge mclk_i);
    fz <= 1'h1;
    abcd(4'h6);
    rd(9'h1a6, d);
    chk("frozen buffer", d, 8'h99);
    @(posedge mclk_i);
    fz <= 1'h0;
    wr(9'h1a7, 8'h60);
    wr(9'h187, 8'h80);
    e1 <= 1'h1;
    fetch_slot(5'h07);
    chk("e1 ab-only sig", sig_q, 4'h5);
    @(posedge mclk_i);
    e1 <= 1'h0;
    $display("test signaling done");
    srst_i <= 1'h1;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'h0;
    rd(9'h184, d);
    chk("control after reset", d, 8'h00);
    chk("pcm after reset", pcm, 8'h00);
    $display("test reset done");
    tally_and_finish;
  end
endmodule // tb_rpcs_top
